// ===== design/pmc_top.sv
`timescale 1ns/100ps
`default_nettype none

// Function
// - four reset sources: power-on, low voltage, reset pin, watchdog overflow
// - power-on loads all control defaults; config word then sets source and threshold
// - pin and watchdog resets clear controls but keep timeout and power-down flags
// - config bit 11 picks low threshold, bit 10 enables low-voltage reset
// - config bit 12 turns regulator and detector off in idle and stop
// - config bits 9-8 select the fast oscillator source
// - config bit 7 enables the external reset pin
// - config bit 6: overflow resets chip, else acts as wake-up timer event
// - config bit 13 blocks external reads of program memory
// - config always readable; writable only unprotected or after erase
// - config bits 4-0 trim the fast internal RC oscillator
// - sleep stops system clock and peripherals; timer follows its settings
// - power-down ends on reset, enabled interrupts, or low wake pin
// - every reset starts in fast mode on the configured fast clock
// - in fast mode timer2 runs fast when its select is set, else slow
// - slow mode: cpu on chosen slow source, fast clock stopped if fast_stop set, peripherals slow
// - sleep with slow enabled and timer2 slow enters idle; only slow logic runs
// - sleep with slow clock disabled enters stop; all oscillators off
// - idle wakes on pin, wake pins, wake timer, timer2; stop not timer2
// - watchdog enabled, sleep timer off: timer cleared in sleep; both on: counts
module pmc_top #(
	parameter int WDT_TICKS = pmc_pkg::WDT_CYCLES
) (
	input  wire logic        REF_CLK,
	input  wire logic        RESET_N,
	// axi4-lite slave
	input  wire logic [3:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [3:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// pins and neighbouring logic
	input  wire logic        RESET_PIN_N,
	input  wire logic        LOW_VOLTAGE,
	input  wire logic [7:0]  WAKE_PINS_N,
	input  wire logic        EXT_PIN_IRQ,
	input  wire logic        TIMER2_IRQ,
	input  wire logic        FAST_TICK,
	input  wire logic        SLOW_TICK,
	// outputs
	output logic             CHIP_RESET_N,
	output logic [1:0]       MODE,
	output logic             CPU_TICK,
	output logic             PERIPH_TICK,
	output logic             TIMER2_TICK,
	output logic             FAST_OSC_EN,
	output logic             SLOW_OSC_EN,
	output logic [1:0]       FAST_SRC_SEL,
	output logic [1:0]       SLOW_SRC_SEL,
	output logic [4:0]       FAST_RC_TRIM,
	output logic             REGULATOR_ON,
	output logic             LVD_ON,
	output logic             LVR_THRESHOLD_LOW,
	output logic             CODE_READ_BLOCK,
	output logic             WAKE_TIMER_EVENT,
	output logic             TIMEOUT_FLAG,
	output logic             POWERDOWN_FLAG
);

	// ------------------------------------------------------------------
	// pin synchronisers: three stages, change taken when 2nd and 3rd agree
	// ------------------------------------------------------------------
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] pin_f;
	assign pin_raw = {LOW_VOLTAGE, RESET_PIN_N, WAKE_PINS_N};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic f_r;
			// pins idle high, the detector idles low
			localparam logic idle_lvl = (gi <= 8);
			// per-pin three-stage filter, every stage seeded at the idle level
			// so that no false wake or reset pulse follows reset
			always_ff @(posedge REF_CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					s1_r <= idle_lvl;
					s2_r <= idle_lvl;
					s3_r <= idle_lvl;
					f_r  <= idle_lvl;
				end else begin
					s1_r <= pin_raw[gi];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r)
						f_r <= s3_r;
				end
			end
			assign pin_f[gi] = f_r;
		end
	endgenerate

	logic       low_volt;
	logic       rst_pin_n;
	logic [7:0] wake_n;
	assign low_volt  = pin_f[9];
	assign rst_pin_n = pin_f[8];
	assign wake_n    = pin_f[7:0];

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [pmc_pkg::CFG_W-1:0]    cfg_r;
	pmc_pkg::pmc_clkctl_type      ctl_r;
	pmc_pkg::pmc_mode_type        mode_r;
	pmc_pkg::pmc_mode_type        mode_nxt;
	logic                         erased_r;
	logic                         to_r;
	logic                         pd_r;
	logic                         chip_rst_r;
	logic [31:0]                  wdt_r;
	logic                         wte_r;
	logic                         cpu_src_r;
	logic                         gate_off_r;

	// ------------------------------------------------------------------
	// configuration decode
	// ------------------------------------------------------------------
	logic protect;
	logic auto_off;
	logic lvr_en;
	logic pin_rst_en;
	logic wdt_rst_en;
	assign protect    = cfg_r[pmc_pkg::CFG_PROTECT];
	assign auto_off   = cfg_r[pmc_pkg::CFG_AUTO_OFF];
	assign lvr_en     = cfg_r[pmc_pkg::CFG_LVR_EN];
	assign pin_rst_en = cfg_r[pmc_pkg::CFG_PIN_RST_EN];
	assign wdt_rst_en = cfg_r[pmc_pkg::CFG_WDT_RST_EN];

	logic sleeping;
	assign sleeping = (mode_r == pmc_pkg::PMC_IDLE) || (mode_r == pmc_pkg::PMC_STOP);

	// regulator and detector follow the auto-off option in sleep
	assign REGULATOR_ON = !(auto_off && sleeping);
	assign LVD_ON       = lvr_en && REGULATOR_ON;

	// ------------------------------------------------------------------
	// shared watchdog / wake-up timer
	// ------------------------------------------------------------------
	logic wdt_run;
	logic wdt_clear_sleep;
	logic wdt_ovf;
	assign wdt_run         = sleeping ? ctl_r.wake_timer_en : (wdt_rst_en || ctl_r.wake_timer_en);
	assign wdt_clear_sleep = sleeping && wdt_rst_en && !ctl_r.wake_timer_en;
	assign wdt_ovf         = wdt_run && (wdt_r == 32'(WDT_TICKS - 1));

	logic wdt_reset;
	logic wkt_event;
	assign wdt_reset = wdt_ovf && wdt_rst_en;
	assign wkt_event = wdt_ovf && !wdt_rst_en;

	// ------------------------------------------------------------------
	// reset sources
	// ------------------------------------------------------------------
	logic pin_reset;
	logic lv_reset;
	logic soft_rst;
	assign pin_reset = pin_rst_en && !rst_pin_n;
	assign lv_reset  = LVD_ON && low_volt;
	assign soft_rst  = pin_reset || lv_reset || wdt_reset;

	// ------------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------------
	logic        aw_got_r;
	logic        w_got_r;
	logic [3:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [1:0]  rresp_r;
	logic [31:0] rdata_r;

	assign S_AXI_AWREADY = !aw_got_r && !bvalid_r;
	assign S_AXI_WREADY  = !w_got_r && !bvalid_r;
	assign S_AXI_ARREADY = !rvalid_r;
	assign S_AXI_BVALID  = bvalid_r;
	assign S_AXI_BRESP   = bresp_r;
	assign S_AXI_RVALID  = rvalid_r;
	assign S_AXI_RRESP   = rresp_r;
	assign S_AXI_RDATA   = rdata_r;

	// write fires once both halves are held
	logic       wr_fire;
	logic       wr_cfg;
	logic       wr_clk;
	logic       wr_cmd;
	logic       wr_ok;
	logic       cfg_allowed;
	assign wr_fire     = aw_got_r && w_got_r;
	assign cfg_allowed = !protect || erased_r;
	assign wr_cfg      = wr_fire && (aw_addr_r == pmc_pkg::OFF_CFG) && cfg_allowed;
	assign wr_clk      = wr_fire && (aw_addr_r == pmc_pkg::OFF_CLK);
	assign wr_cmd      = wr_fire && (aw_addr_r == pmc_pkg::OFF_CMD);
	assign wr_ok       = wr_cfg || wr_clk || wr_cmd || (wr_fire && aw_addr_r == pmc_pkg::OFF_STAT);

	logic cmd_sleep;
	logic cmd_clrwd;
	logic cmd_erase;
	assign cmd_sleep = wr_cmd && w_data_r[pmc_pkg::CMD_SLEEP];
	assign cmd_clrwd = wr_cmd && w_data_r[pmc_pkg::CMD_CLRWD];
	assign cmd_erase = wr_cmd && w_data_r[pmc_pkg::CMD_ERASE];

	// read data mux
	logic [31:0] rd_mux;
	logic        rd_hit;
	logic [31:0] stat_word;
	assign stat_word = {24'h000000, erased_r, cpu_src_r, pd_r, to_r, 2'b00, mode_r};
	assign rd_hit    = (S_AXI_ARADDR == pmc_pkg::OFF_CFG) || (S_AXI_ARADDR == pmc_pkg::OFF_CLK)
	                || (S_AXI_ARADDR == pmc_pkg::OFF_CMD) || (S_AXI_ARADDR == pmc_pkg::OFF_STAT);
	assign rd_mux    = (S_AXI_ARADDR == pmc_pkg::OFF_CFG)  ? {18'h00000, cfg_r} :
	                   (S_AXI_ARADDR == pmc_pkg::OFF_CLK)  ? {25'h0000000, ctl_r} :
	                   (S_AXI_ARADDR == pmc_pkg::OFF_STAT) ? stat_word : 32'h00000000;

	// address and data capture, response
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			aw_addr_r <= 4'h0;
			w_data_r  <= 32'h00000000;
			bvalid_r  <= 1'b0;
			bresp_r   <= 2'b00;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= {S_AXI_AWADDR[3:2], 2'b00};
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_got_r  <= 1'b1;
				w_data_r <= S_AXI_WDATA & {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
				                           {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
			end
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= wr_ok ? 2'b00 : 2'b10;
			end else if (bvalid_r && S_AXI_BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// read channel
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rvalid_r <= 1'b0;
			rresp_r  <= 2'b00;
			rdata_r  <= 32'h00000000;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_r <= 1'b1;
			rresp_r  <= rd_hit ? 2'b00 : 2'b10;
			rdata_r  <= rd_mux;
		end else if (rvalid_r && S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// configuration word and erase state
	// ------------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cfg_r    <= pmc_pkg::CFG_RESET;
			erased_r <= 1'b0;
		end else begin
			if (wr_cfg)
				cfg_r <= w_data_r[pmc_pkg::CFG_W-1:0];
			if (cmd_erase)
				erased_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// clock control register: defaults on any reset
	// ------------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			ctl_r <= pmc_pkg::CLKCTL_RESET;
		else if (soft_rst)
			ctl_r <= pmc_pkg::CLKCTL_RESET;
		else if (wr_clk)
			ctl_r <= w_data_r[pmc_pkg::CLKCTL_W-1:0];
	end

	// ------------------------------------------------------------------
	// operating mode
	// ------------------------------------------------------------------
	logic wake;
	assign wake = EXT_PIN_IRQ || (wake_n != 8'hff) || wkt_event
	           || (mode_r == pmc_pkg::PMC_IDLE && TIMER2_IRQ);

	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			pmc_pkg::PMC_FAST, pmc_pkg::PMC_SLOW: begin
				mode_nxt = cpu_src_r ? pmc_pkg::PMC_SLOW : pmc_pkg::PMC_FAST;
				if (cmd_sleep) begin
					if (ctl_r.slow_en && !ctl_r.t2_fast)
						mode_nxt = pmc_pkg::PMC_IDLE;
					else
						mode_nxt = pmc_pkg::PMC_STOP;
				end
			end
			pmc_pkg::PMC_IDLE, pmc_pkg::PMC_STOP: begin
				if (wake)
					mode_nxt = cpu_src_r ? pmc_pkg::PMC_SLOW : pmc_pkg::PMC_FAST;
			end
		endcase
	end

	// mode register, reset returns to fast mode
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			mode_r <= pmc_pkg::PMC_FAST;
		else if (soft_rst)
			mode_r <= pmc_pkg::PMC_FAST;
		else
			mode_r <= mode_nxt;
	end

	// ------------------------------------------------------------------
	// watchdog counter and flags
	// ------------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			wdt_r <= 32'h00000000;
		else if (soft_rst || cmd_clrwd || cmd_sleep || wdt_clear_sleep || wdt_ovf)
			wdt_r <= 32'h00000000;
		else if (wdt_run)
			wdt_r <= wdt_r + 32'h00000001;
	end

	// timeout and power-down flags survive pin and watchdog resets
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			to_r <= 1'b0;
			pd_r <= 1'b0;
		end else if (lv_reset) begin
			to_r <= 1'b0;
			pd_r <= 1'b0;
		end else if (!(pin_reset || wdt_reset)) begin
			if (wkt_event)
				to_r <= 1'b1;
			else if (cmd_clrwd || cmd_sleep)
				to_r <= 1'b0;
			if (cmd_sleep)
				pd_r <= 1'b1;
			else if (cmd_clrwd)
				pd_r <= 1'b0;
		end
	end

	// event pulse and chip reset output
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wte_r      <= 1'b0;
			chip_rst_r <= 1'b1;
		end else begin
			wte_r      <= wkt_event;
			chip_rst_r <= soft_rst;
		end
	end

	// ------------------------------------------------------------------
	// glitch-free cpu clock selection
	// ------------------------------------------------------------------
	logic old_tick;
	logic new_tick;
	assign old_tick = cpu_src_r ? SLOW_TICK : FAST_TICK;
	assign new_tick = ctl_r.slow_sel ? SLOW_TICK : FAST_TICK;

	// gate off after the old source's tick, switch on the new one's tick
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cpu_src_r  <= 1'b0;
			gate_off_r <= 1'b0;
		end else if (soft_rst) begin
			cpu_src_r  <= 1'b0;
			gate_off_r <= 1'b0;
		end else if (!gate_off_r) begin
			if (ctl_r.slow_sel != cpu_src_r && old_tick)
				gate_off_r <= 1'b1;
		end else if (new_tick) begin
			cpu_src_r  <= ctl_r.slow_sel;
			gate_off_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// clock distribution
	// ------------------------------------------------------------------
	logic run;
	assign run = !sleeping && !chip_rst_r;

	assign CPU_TICK     = run && !gate_off_r && old_tick;
	assign PERIPH_TICK  = run && !gate_off_r && old_tick;
	assign TIMER2_TICK  = (mode_r == pmc_pkg::PMC_FAST) ? (ctl_r.t2_fast ? FAST_TICK : SLOW_TICK)
	                    : (mode_r == pmc_pkg::PMC_STOP) ? 1'b0 : SLOW_TICK;
	assign FAST_OSC_EN  = (mode_r == pmc_pkg::PMC_FAST) || (mode_r == pmc_pkg::PMC_SLOW && !ctl_r.fast_stop);
	assign SLOW_OSC_EN  = ctl_r.slow_en && (mode_r != pmc_pkg::PMC_STOP);

	// configuration outputs
	assign FAST_SRC_SEL      = cfg_r[pmc_pkg::CFG_SRC_HI:pmc_pkg::CFG_SRC_LO];
	assign SLOW_SRC_SEL      = ctl_r.slow_type;
	assign FAST_RC_TRIM      = cfg_r[pmc_pkg::CFG_TRIM_HI:0];
	assign LVR_THRESHOLD_LOW = cfg_r[pmc_pkg::CFG_LVR_LOW];
	assign CODE_READ_BLOCK   = protect;
	assign WAKE_TIMER_EVENT  = wte_r;
	assign TIMEOUT_FLAG      = to_r;
	assign POWERDOWN_FLAG    = pd_r;
	assign MODE              = mode_r;
	assign CHIP_RESET_N      = !chip_rst_r;

endmodule

`default_nettype wire

// ===== design/pmc_pkg.sv
package pmc_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [3:0] OFF_CFG  = 4'h0;
	localparam logic [3:0] OFF_CLK  = 4'h4;
	localparam logic [3:0] OFF_CMD  = 4'h8;
	localparam logic [3:0] OFF_STAT = 4'hc;

	// ------------------------------------------------------------------
	// configuration word layout
	// ------------------------------------------------------------------
	localparam int CFG_W           = 14;
	localparam int CFG_PROTECT     = 13;
	localparam int CFG_AUTO_OFF    = 12;
	localparam int CFG_LVR_LOW     = 11;
	localparam int CFG_LVR_EN      = 10;
	localparam int CFG_SRC_HI      = 9;
	localparam int CFG_SRC_LO      = 8;
	localparam int CFG_PIN_RST_EN  = 7;
	localparam int CFG_WDT_RST_EN  = 6;
	localparam int CFG_TRIM_HI     = 4;
	localparam logic [13:0] CFG_RESET = 14'h0000;

	// command register bits (write-one pulses)
	localparam int CMD_SLEEP = 0;
	localparam int CMD_CLRWD = 1;
	localparam int CMD_ERASE = 2;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ         = 50;
	localparam int WDT_PERIOD_US   = 14000;
	localparam int WDT_CYCLES      = WDT_PERIOD_US * CLK_MHZ;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PMC_FAST = 2'b00,
		PMC_SLOW = 2'b01,
		PMC_IDLE = 2'b11,
		PMC_STOP = 2'b10
	} pmc_mode_type;

	typedef struct packed {
		logic       wake_timer_en;
		logic [1:0] slow_type;
		logic       t2_fast;
		logic       fast_stop;
		logic       slow_sel;
		logic       slow_en;
	} pmc_clkctl_type;

	localparam pmc_clkctl_type CLKCTL_RESET = '0;
	localparam int CLKCTL_W = 7;

endpackage

// ===== test/pmc_osc_model.sv
`timescale 1ns/100ps
`default_nettype none

module pmc_osc_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic fast_en,
	input  wire logic slow_en,
	output logic      fast_tick,
	output logic      slow_tick
);
	// ------------------------------------------------------------
	// oscillator edges
	// ------------------------------------------------------------
	logic [2:0] cnt_r;

	// free phase counter shared by both oscillators
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= 3'h0;
		else
			cnt_r <= cnt_r + 3'h1;
	end

	// a disabled oscillator gives no edges at all; the slow source assumes
	// firmware left its oscillator pins as pulled-up inputs
	assign fast_tick = fast_en & cnt_r[0];
	assign slow_tick = slow_en & (cnt_r == 3'h6);
endmodule

`default_nettype wire

// ===== test/pmc_properties.sv
`timescale 1ns/100ps
`default_nettype none

module pmc_properties (
	input wire logic       REF_CLK,
	input wire logic       RESET_N,
	input wire logic [1:0] MODE,
	input wire logic       CPU_TICK,
	input wire logic       PERIPH_TICK,
	input wire logic       TIMER2_TICK,
	input wire logic       FAST_TICK,
	input wire logic       SLOW_TICK,
	input wire logic       FAST_OSC_EN,
	input wire logic       SLOW_OSC_EN,
	input wire logic       CHIP_RESET_N,
	input wire logic       LVD_ON,
	input wire logic       REGULATOR_ON,
	input wire logic       POWERDOWN_FLAG,
	input wire logic       EXT_PIN_IRQ,
	input wire logic       TIMER2_IRQ,
	input wire logic       WAKE_TIMER_EVENT
);
	// ------------------------------------------------------------
	// mode, clock and reset relations
	// ------------------------------------------------------------
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	a_sleep_no_cpu: assert property (MODE[1] |-> !CPU_TICK && !PERIPH_TICK)
		else $error("cpu tick while asleep");
	a_stop_all_off: assert property (MODE == 2'b10 |-> !FAST_OSC_EN && !SLOW_OSC_EN && !TIMER2_TICK)
		else $error("clock alive in stop");
	a_idle_slow_only: assert property (MODE == 2'b11 |-> SLOW_OSC_EN && !FAST_OSC_EN)
		else $error("idle oscillators wrong");
	a_tick_source: assert property (CPU_TICK |-> FAST_TICK || SLOW_TICK)
		else $error("cpu tick without source edge");
	a_reset_fast: assert property (!CHIP_RESET_N |-> MODE == 2'b00)
		else $error("reset not in fast mode");
	a_run_regulator: assert property (!MODE[1] && !$past(MODE[1]) |-> REGULATOR_ON)
		else $error("regulator off while running");
	a_flags_keep: assert property ($fell(CHIP_RESET_N) && !LVD_ON |-> POWERDOWN_FLAG == $past(POWERDOWN_FLAG, 1))
		else $error("powerdown flag lost on reset");
	a_stop_ext_wake: assert property (MODE == 2'b10 && EXT_PIN_IRQ |=> !MODE[1])
		else $error("no wake from stop");
	a_idle_t2_wake: assert property (MODE == 2'b11 && TIMER2_IRQ |=> !MODE[1])
		else $error("no timer2 wake from idle");
	a_event_no_reset: assert property (WAKE_TIMER_EVENT |-> CHIP_RESET_N ##1 CHIP_RESET_N)
		else $error("wake event caused reset");

	c_idle: cover property (MODE == 2'b11);
	c_stop: cover property (MODE == 2'b10);
	c_chip_reset: cover property ($fell(CHIP_RESET_N));
endmodule

bind pmc_top pmc_properties u_props (
	.REF_CLK, .RESET_N, .MODE, .CPU_TICK, .PERIPH_TICK, .TIMER2_TICK, .FAST_TICK, .SLOW_TICK,
	.FAST_OSC_EN, .SLOW_OSC_EN, .CHIP_RESET_N, .LVD_ON, .REGULATOR_ON, .POWERDOWN_FLAG,
	.EXT_PIN_IRQ, .TIMER2_IRQ, .WAKE_TIMER_EVENT
);

`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        ref_clk, reset_n, aw_v, aw_rdy, w_v, w_rdy, b_v, b_rdy, ar_v, ar_rdy, r_v, r_rdy;
	logic        pin_rst_n, low_v, ext_irq, t2_irq, f_tick, s_tick, chip_rst_n, t2_tick, f_en, s_en;
	logic        reg_on, lvd_on, lvr_low, blk, wt_ev, to_flag, pd_flag;
	logic [1:0]  b_resp, r_resp, mode, f_sel, s_sel;
	logic [3:0]  aw_addr, ar_addr;
	logic [4:0]  trim;
	logic [7:0]  wake_n;
	logic [31:0] w_data, r_data, cfg;
	int          errors, checks, i, n;

	pmc_top #(.WDT_TICKS(20)) u_dut (
		.REF_CLK(ref_clk), .RESET_N(reset_n), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_v),
		.S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_v),
		.S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_rdy),
		.S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_data),
		.S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_rdy), .RESET_PIN_N(pin_rst_n),
		.LOW_VOLTAGE(low_v), .WAKE_PINS_N(wake_n), .EXT_PIN_IRQ(ext_irq), .TIMER2_IRQ(t2_irq),
		.FAST_TICK(f_tick), .SLOW_TICK(s_tick), .CHIP_RESET_N(chip_rst_n), .MODE(mode),
		.CPU_TICK(), .PERIPH_TICK(), .TIMER2_TICK(t2_tick), .FAST_OSC_EN(f_en), .SLOW_OSC_EN(s_en),
		.FAST_SRC_SEL(f_sel), .SLOW_SRC_SEL(s_sel), .FAST_RC_TRIM(trim), .REGULATOR_ON(reg_on),
		.LVD_ON(lvd_on), .LVR_THRESHOLD_LOW(lvr_low), .CODE_READ_BLOCK(blk),
		.WAKE_TIMER_EVENT(wt_ev), .TIMEOUT_FLAG(to_flag), .POWERDOWN_FLAG(pd_flag)
	);

	pmc_osc_model u_osc (
		.clk(ref_clk), .rst_n(reset_n), .fast_en(f_en), .slow_en(s_en), .fast_tick(f_tick), .slow_tick(s_tick)
	);

	// ------------------------------------------------------------
	// clock, tasks
	// ------------------------------------------------------------
	always #10 ref_clk = ~ref_clk;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic close_out();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// axi write: each half released when taken, then wait for response
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge ref_clk);
		aw_addr <= a;
		w_data <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		fork
			begin
				@(posedge ref_clk iff aw_rdy);
				aw_v <= 1'b0;
			end
			begin
				@(posedge ref_clk iff w_rdy);
				w_v <= 1'b0;
			end
		join
		@(posedge ref_clk iff b_v);
		b_rdy <= 1'b0;
		chk(32'(b_resp), 32'(er));
	endtask

	// axi read with expected word
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		ar_addr <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		@(posedge ref_clk iff ar_rdy);
		ar_v <= 1'b0;
		@(posedge ref_clk iff r_v);
		r_rdy <= 1'b0;
		chk(r_data, e);
	endtask

	// hang guard
	initial begin
		repeat (5000) @(posedge ref_clk);
		errors++;
		close_out();
	end

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		{ref_clk, reset_n, aw_v, w_v, b_rdy, ar_v, r_rdy, low_v, ext_irq, t2_irq} = '0;
		{pin_rst_n, wake_n, aw_addr, ar_addr, w_data, errors, checks} = {1'b1, 8'hff, 40'h0, 64'h0};
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(pmc_pkg::OFF_CFG, 32'h0);
		rd(pmc_pkg::OFF_STAT, 32'h0);
		for (i = 0; i < 4; i++) begin
			cfg = (32'(i) << 8) | (32'(i & 1) << 11) | 32'(i * 9);
			wr(pmc_pkg::OFF_CFG, cfg, 2'b00);
			rd(pmc_pkg::OFF_CFG, cfg);
			@(negedge ref_clk);
			chk(32'(f_sel), 32'(i));
			chk(32'(trim), 32'(i * 9));
			chk(32'(lvr_low), 32'(i & 1));
		end
		// fast to slow and back
		wr(pmc_pkg::OFF_CLK, 32'h1, 2'b00);
		wr(pmc_pkg::OFF_CLK, 32'h3, 2'b00);
		repeat (12) @(posedge ref_clk);
		wr(pmc_pkg::OFF_CLK, 32'h7, 2'b00);
		repeat (20) @(posedge ref_clk);
		rd(pmc_pkg::OFF_STAT, 32'h41);
		@(negedge ref_clk);
		chk(32'(f_en), 32'h0);
		wr(pmc_pkg::OFF_CLK, 32'h3, 2'b00);
		repeat (12) @(posedge ref_clk);
		wr(pmc_pkg::OFF_CLK, 32'h1, 2'b00);
		repeat (20) @(posedge ref_clk);
		rd(pmc_pkg::OFF_STAT, 32'h0);
		// timer2 source in fast mode
		wr(pmc_pkg::OFF_CLK, 32'h39, 2'b00);
		repeat (8) begin
			@(negedge ref_clk);
			chk(32'(t2_tick), 32'(f_tick));
		end
		chk(32'(s_sel), 32'h3);
		wr(pmc_pkg::OFF_CLK, 32'h1, 2'b00);
		repeat (16) begin
			@(negedge ref_clk);
			chk(32'(t2_tick), 32'(s_tick));
		end
		// idle entry, timer2 wake
		wr(pmc_pkg::OFF_CMD, 32'h1, 2'b00);
		@(negedge ref_clk);
		chk(32'(mode), 32'h3);
		chk(32'(pd_flag), 32'h1);
		@(posedge ref_clk);
		t2_irq <= 1'b1;
		@(posedge ref_clk);
		t2_irq <= 1'b0;
		@(negedge ref_clk);
		chk(32'(mode), 32'h0);
		// stop entry with regulator auto off
		wr(pmc_pkg::OFF_CFG, 32'h1000, 2'b00);
		wr(pmc_pkg::OFF_CLK, 32'h0, 2'b00);
		wr(pmc_pkg::OFF_CMD, 32'h1, 2'b00);
		@(posedge ref_clk);
		t2_irq <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t2_irq <= 1'b0;
		@(negedge ref_clk);
		chk(32'(mode), 32'h2);
		chk(32'(reg_on), 32'h0);
		@(posedge ref_clk);
		ext_irq <= 1'b1;
		@(posedge ref_clk);
		ext_irq <= 1'b0;
		@(negedge ref_clk);
		chk(32'(mode), 32'h0);
		wr(pmc_pkg::OFF_CMD, 32'h1, 2'b00);
		@(posedge ref_clk);
		wake_n <= 8'h7f;
		repeat (6) @(posedge ref_clk);
		wake_n <= 8'hff;
		@(negedge ref_clk);
		chk(32'(mode), 32'h0);
		chk(32'(reg_on), 32'h1);
		// pin reset disabled then enabled
		for (i = 0; i < 2; i++) begin
			wr(pmc_pkg::OFF_CFG, 32'(i) << 7, 2'b00);
			wr(pmc_pkg::OFF_CLK, 32'h1, 2'b00);
			@(posedge ref_clk);
			pin_rst_n <= 1'b0;
			repeat (8) @(posedge ref_clk);
			pin_rst_n <= 1'b1;
			repeat (6) @(posedge ref_clk);
			rd(pmc_pkg::OFF_CLK, 32'(1 - i));
		end
		// watchdog reset
		wr(pmc_pkg::OFF_CFG, 32'h40, 2'b00);
		n = 0;
		while (chip_rst_n !== 1'b0 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		chk(32'(n < 100), 32'h1);
		wr(pmc_pkg::OFF_CFG, 32'h0, 2'b00);
		@(negedge ref_clk);
		chk(32'(pd_flag), 32'h1);
		// wake timer event without reset
		wr(pmc_pkg::OFF_CLK, 32'h40, 2'b00);
		n = 0;
		while (wt_ev !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		chk(32'(n < 100), 32'h1);
		wr(pmc_pkg::OFF_CLK, 32'h0, 2'b00);
		@(negedge ref_clk);
		chk(32'(to_flag), 32'h1);
		// low voltage reset clears both flags
		wr(pmc_pkg::OFF_CFG, 32'h400, 2'b00);
		wr(pmc_pkg::OFF_CLK, 32'h1, 2'b00);
		@(negedge ref_clk);
		chk(32'(lvd_on), 32'h1);
		@(posedge ref_clk);
		low_v <= 1'b1;
		repeat (8) @(posedge ref_clk);
		low_v <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rd(pmc_pkg::OFF_CLK, 32'h0);
		rd(pmc_pkg::OFF_STAT, 32'h0);
		// protection and erase
		wr(pmc_pkg::OFF_CFG, 32'h2000, 2'b00);
		@(negedge ref_clk);
		chk(32'(blk), 32'h1);
		wr(pmc_pkg::OFF_CFG, 32'h0, 2'b10);
		rd(pmc_pkg::OFF_CFG, 32'h2000);
		wr(pmc_pkg::OFF_CMD, 32'h4, 2'b00);
		rd(pmc_pkg::OFF_STAT, 32'h80);
		wr(pmc_pkg::OFF_CFG, 32'h0, 2'b00);
		rd(pmc_pkg::OFF_CFG, 32'h0);
		close_out();
	end
endmodule

`default_nettype wire
